// ### sim/asr_host_test.sv
`timescale 1ns/100ps
`default_nettype none

module asr_host_test;
  import asr_pkg::*;
  logic sys_clk = 0, sys_rst = 1, req_valid = 0, retention_exit = 0, tgl = 0;
  asr_req_t req = '0;
  logic req_ready, rd_valid, cs_n, oe_n, we_n, lb_n, ub_n;
  logic [15:0] rd_data, bus, d_out, m_q, q;
  logic [15:0] addr;
  logic [1:0] d_oe, m_oe;
  logic [7:0] flt;
  int fails = 0, num_checks = 0, cs_cnt = 0, we_cnt = 0, sel_cnt = 0;
  always #5 sys_clk = ~sys_clk;
  // Undriven lanes toggle so a stale value can never pass for read data.
  assign flt = {8{tgl}} ^ 8'h5a;
  assign bus[7:0] = d_oe[0] ? d_out[7:0] : m_oe[0] ? m_q[7:0] : flt;
  assign bus[15:8] = d_oe[1] ? d_out[15:8] : m_oe[1] ? m_q[15:8] : flt;
  asr_host dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .retention_exit(retention_exit), .word_address(addr), .chip_select_n(cs_n),
    .output_enable_n(oe_n), .write_strobe_n(we_n), .low_byte_sel_n(lb_n),
    .high_byte_sel_n(ub_n), .data_bus_in(bus), .data_bus_out(d_out), .data_bus_oe(d_oe));
  asr_sram_model mem_i (.word_address(addr), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_strobe_n(we_n), .low_byte_sel_n(lb_n), .high_byte_sel_n(ub_n), .data_bus(bus),
    .mem_q(m_q), .mem_oe(m_oe));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  always @(posedge sys_clk) begin
    tgl <= ~tgl;
    cs_cnt <= cs_n ? 0 : cs_cnt + 1;
    we_cnt <= we_n ? 0 : we_cnt + 1;
    sel_cnt <= (lb_n && ub_n) ? 0 : sel_cnt + 1;
    if (!sys_rst) begin
      chk("contention", {14'h0, d_oe & m_oe}, 16'h0);
      chk("strobe_in_read", {15'h0, !oe_n && !we_n}, 16'h0);
      if (cs_n && cs_cnt != 0)
        chk("cycle_short", {15'h0, cs_cnt < READ_CYCLE_CYC}, 16'h0);
      if (we_n && we_cnt != 0)
        chk("strobe_short", {15'h0, we_cnt < WRITE_CYCLE_CYC}, 16'h0);
      if (lb_n && ub_n && !we_n && sel_cnt != 0)
        chk("lane_pulse", {15'h0, sel_cnt < STROBE_CYC}, 16'h0);
    end
  end
  task op(input logic wr, input logic [1:0] ln, input logic [15:0] a, input logic [15:0] d);
    int n;
    req <= '{write: wr, lane_en: ln, addr: a, wdata: d};
    req_valid <= 1'b1;
    n = 0;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge sys_clk);
    end
    req_valid <= 1'b0;
    if (n >= 40) begin
      chk("ready", 16'h0, 16'h1);
      test_done;
    end
    // A write returns one edge later so the next request never reuses this time step.
    if (wr) @(posedge sys_clk);
    if (!wr) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (rd_valid !== 1'b1 && n < 40);
      chk("rd_latency", n[15:0], 16'h6);
      q = rd_data;
    end
  endtask : op
  task t_full;
    op(1, 2'h3, 16'hffff, 16'ha55a);
    op(1, 2'h3, 16'h0000, 16'h1234);
    op(0, 2'h3, 16'hffff, 16'h0);
    chk("rd_top", q, 16'ha55a);
    op(0, 2'h3, 16'h0000, 16'h0);
    chk("rd_bottom", q, 16'h1234);
    $display("t_full done");
  endtask : t_full
  task t_lane;
    op(1, 2'h3, 16'h0100, 16'hbeef);
    op(1, 2'h1, 16'h0100, 16'h0011);
    op(1, 2'h2, 16'h0100, 16'h2200);
    op(0, 2'h3, 16'h0100, 16'h0);
    chk("lane_merge", q, 16'h2211);
    op(0, 2'h1, 16'h0100, 16'h0);
    chk("rd_low", {8'h0, q[7:0]}, 16'h0011);
    op(0, 2'h2, 16'h0100, 16'h0);
    chk("rd_high", {q[15:8], 8'h0}, 16'h2200);
    op(1, 2'h0, 16'h0200, 16'h3344);
    op(0, 2'h0, 16'h0200, 16'h0);
    chk("no_lane_both", q, 16'h3344);
    $display("t_lane done");
  endtask : t_lane
  task t_retn;
    int n;
    retention_exit <= 1'b1;
    @(posedge sys_clk);
    retention_exit <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    chk("recovery", {15'h0, n > RECOVERY_CYC}, 16'h1);
    op(0, 2'h3, 16'h0100, 16'h0);
    chk("rd_after_retn", q, 16'h2211);
    $display("t_retn done");
  endtask : t_retn
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_full;
    t_lane;
    t_retn;
    test_done;
  end
endmodule : asr_host_test

`default_nettype wire

// ### sim/asr_sram_model.sv
`timescale 1ns/100ps
`default_nettype none

module asr_sram_model
  import asr_pkg::*;
(
  input wire logic [asr_pkg::ADDR_W-1:0] word_address,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_byte_sel_n,
  input wire logic high_byte_sel_n,
  input wire logic [asr_pkg::DATA_W-1:0] data_bus,
  output logic [asr_pkg::DATA_W-1:0] mem_q,
  output logic [asr_pkg::LANES-1:0] mem_oe
);
  logic [DATA_W-1:0] mem [0:65535];
  wire logic sel_w = !chip_select_n;
  wire logic rd_w = sel_w && write_strobe_n && !output_enable_n;
  wire logic wr_w = sel_w && !write_strobe_n;
  // Release is instant on strobe fall, which is kinder than a real part.
  assign mem_oe = {rd_w && !high_byte_sel_n,
    rd_w && !low_byte_sel_n};
  assign mem_q = mem[word_address];
  always @(*) begin
    if (wr_w && !low_byte_sel_n) mem[word_address][7:0] = data_bus[7:0];
    if (wr_w && !high_byte_sel_n) mem[word_address][15:8] = data_bus[15:8];
  end
endmodule : asr_sram_model

`default_nettype wire

// ### verilog/asr_host.sv
// Overview of operation
// - Any of three going high ends write.
// - Strobe held low, lane pulses frame writes.
// - Strobe stays high through every read.
// - Address valid by chip select falling.
// - Reads spaced by read cycle time.
// - Writes last at least write cycle time.
// - Strobe pulse meets minimum width.
// - Wait read cycle after retention exit; an exit seen outside ST_IDLE is ignored.
`timescale 1ns/100ps
`default_nettype none

module asr_host
  import asr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire asr_pkg::asr_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [asr_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic retention_exit,
  output logic [asr_pkg::ADDR_W-1:0] word_address,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic low_byte_sel_n,
  output logic high_byte_sel_n,
  input wire logic [asr_pkg::DATA_W-1:0] data_bus_in,
  output logic [asr_pkg::DATA_W-1:0] data_bus_out,
  output logic [asr_pkg::LANES-1:0] data_bus_oe
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] din_s1_r;
  logic [DATA_W-1:0] din_s2_r;

  always_ff @(posedge sys_clk) begin
    din_s1_r <= data_bus_in;
    din_s2_r <= din_s1_r;
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Reads wait two extra cycles so sampled data has crossed the synchroniser.
  localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYCLE_CYC + 2);
  localparam logic [CNT_W-1:0] REL_CNT = CNT_W'(RELEASE_CYC);
  localparam logic [CNT_W-1:0] STB_CNT = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(RECOVERY_CYC);

  asr_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  asr_req_t cur_r;
  asr_ctl_t ctl_r, ctl_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic rd_valid_r, rd_valid_nxt;
  logic req_ready_r;
  logic [LANES-1:0] oe_r, oe_nxt;

  wire cnt_done = (cnt_r == '0);
  wire take = req_valid && req_ready_r;
  wire [CNT_W-1:0] cnt_dec = cnt_done ? cnt_r : cnt_r - CNT_W'(1);
  // A request with no lane enabled would be a null cycle, so both lanes are used.
  wire [LANES-1:0] lanes = (req.lane_en == '0) ? {LANES{1'b1}} : req.lane_en;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_dec;
    ctl_nxt = ctl_r;
    oe_nxt = oe_r;
    rd_valid_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        ctl_nxt = CTL_IDLE;
        oe_nxt = '0;
        if (retention_exit) begin
          state_nxt = ST_RECOVER;
          cnt_nxt = REC_CNT;
        end else if (take && !req.write) begin
          // Address and select change together, so address is valid at the fall.
          ctl_nxt = '{1'b0, 1'b0, 1'b1, !lanes[0], !lanes[1]};
          state_nxt = ST_READ;
          cnt_nxt = READ_CNT;
        end else if (take) begin
          // Output enable stays high so the device never drives during writes.
          ctl_nxt = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
          state_nxt = ST_WREL;
          cnt_nxt = REL_CNT;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          rd_valid_nxt = 1'b1;
          ctl_nxt = CTL_IDLE;
          state_nxt = ST_IDLE;
        end
      end
      ST_WREL: begin
        if (cnt_done) begin
          ctl_nxt.low_byte_sel_n = !cur_r.lane_en[0];
          ctl_nxt.high_byte_sel_n = !cur_r.lane_en[1];
          oe_nxt = cur_r.lane_en;
          state_nxt = ST_WRITE;
          cnt_nxt = STB_CNT;
        end
      end
      ST_WRITE: begin
        if (cnt_done) begin
          // Lane selects rise first; strobe low across words is legal.
          ctl_nxt.low_byte_sel_n = 1'b1;
          ctl_nxt.high_byte_sel_n = 1'b1;
          state_nxt = ST_WEND;
        end
      end
      ST_WEND: begin
        ctl_nxt = CTL_IDLE;
        oe_nxt = '0; // Data held one cycle past the write end.
        state_nxt = ST_IDLE;
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ctl_nxt = CTL_IDLE;
        oe_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      ctl_r <= CTL_IDLE;
      oe_r <= '0;
      rd_valid_r <= 1'b0;
      req_ready_r <= 1'b0;
      cur_r <= '0;
      rd_data_r <= DATA_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ctl_r <= ctl_nxt;
      oe_r <= oe_nxt;
      rd_valid_r <= rd_valid_nxt;
      req_ready_r <= (state_nxt == ST_IDLE) && !take;
      if (take && state_r == ST_IDLE && !retention_exit) begin
        cur_r <= '{req.write, lanes, req.addr, req.wdata};
      end
      if (rd_valid_nxt) begin
        rd_data_r <= din_s2_r;
      end
    end
  end

  assign req_ready = req_ready_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign word_address = cur_r.addr;
  assign chip_select_n = ctl_r.chip_select_n;
  assign output_enable_n = ctl_r.output_enable_n;
  assign write_strobe_n = ctl_r.write_strobe_n;
  assign low_byte_sel_n = ctl_r.low_byte_sel_n;
  assign high_byte_sel_n = ctl_r.high_byte_sel_n;
  assign data_bus_out = cur_r.wdata;
  assign data_bus_oe = oe_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  strobe_in_read_a: assert property (!output_enable_n |-> write_strobe_n)
    else $error("strobe low while reading");
  no_contention_a: assert property (|data_bus_oe |-> output_enable_n)
    else $error("bus driven while device enabled");
  drive_after_release_a: assert property ($rose(|data_bus_oe) |->
    !$past(write_strobe_n) && $past(output_enable_n))
    else $error("bus driven before release");
  sequence strobe_fall_s;
    $fell(low_byte_sel_n && high_byte_sel_n) && !write_strobe_n;
  endsequence
  pulse_width_a: assert property (strobe_fall_s |->
    !(low_byte_sel_n && high_byte_sel_n) [*2])
    else $error("write pulse too short");
  write_length_a: assert property ($fell(write_strobe_n) |->
    !write_strobe_n [*3])
    else $error("write cycle too short");
  read_length_a: assert property ($fell(chip_select_n) && !output_enable_n |->
    !chip_select_n [*4])
    else $error("read cycle too short");
  addr_stable_a: assert property (!chip_select_n && !$fell(chip_select_n) |->
    $stable(word_address))
    else $error("address moved during access");
  idle_quiet_a: assert property (chip_select_n |-> data_bus_oe == '0)
    else $error("bus driven while deselected");
  lane_gate_a: assert property (data_bus_oe[0] |-> !low_byte_sel_n || !$past(low_byte_sel_n))
    else $error("low lane driven unselected");
  recovery_wait_a: assert property ($rose(retention_exit) && state_r == ST_IDLE |=>
    (chip_select_n && !req_ready) [*2])
    else $error("access during recovery");

endmodule : asr_host

`default_nettype wire

// ### verilog/asr_pkg.sv
package asr_pkg;

  // ------------------------------------------------------------------
  // Widths and bus encodings
  // ------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LANES = 2;

  // ------------------------------------------------------------------
  // Timing figures in ns and derived cycle counts at 100 MHz
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_CYCLE_NS = 15;
  localparam int WRITE_CYCLE_NS = 15;
  localparam int STROBE_PULSE_OE_HIGH_NS = 10;
  localparam int STROBE_PULSE_OE_LOW_NS = 12;
  localparam int BUS_RELEASE_NS = 7;
  localparam int READ_CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC =
    (STROBE_PULSE_OE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (BUS_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = READ_CYCLE_CYC;
  localparam int CNT_W = 4;

  // ------------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef struct packed {
    logic write;
    logic [LANES-1:0] lane_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_t;

  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic low_byte_sel_n;
    logic high_byte_sel_n;
  } asr_ctl_t;

  localparam asr_ctl_t CTL_IDLE = 5'h1f;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WREL = 3'b010,
    ST_WRITE = 3'b011,
    ST_WEND = 3'b100,
    ST_RECOVER = 3'b101
  } asr_state_t;

endpackage : asr_pkg
